/* File: core/psot_pkg.sv */
/*
  Shared constants for the protection stage operate/release timing block:
  register map, field positions, reset values, timing counts and state codes.
  Assumes a 25 MHz system clock and a 5 ms evaluation tick.
*/
package psot_pkg;
  // Clock and evaluation tick
  localparam int CLK_MHZ = 25;
  localparam int EVAL_PERIOD_US = 5000;
  localparam int TICK_CYCLES_DEF = EVAL_PERIOD_US * CLK_MHZ;
  localparam int TICK_MS = 5;

  // Time fields in ticks
  localparam int TW = 19;
  localparam int MAX_TIME_MS = 1800000;
  localparam logic [TW-1:0] MAX_TICKS = TW'(MAX_TIME_MS / TICK_MS);
  localparam int OP_DELAY_DEF_MS = 40;
  localparam int REL_DELAY_DEF_MS = 60;
  localparam logic [TW-1:0] OP_DELAY_RESET = TW'(OP_DELAY_DEF_MS / TICK_MS);
  localparam logic [TW-1:0] REL_DELAY_RESET = TW'(REL_DELAY_DEF_MS / TICK_MS);

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PICKUP = 8'h04;
  localparam logic [7:0] REG_OP_DELAY = 8'h08;
  localparam logic [7:0] REG_TIME_DIAL = 8'h0C;
  localparam logic [7:0] REG_EXPONENT = 8'h10;
  localparam logic [7:0] REG_REL_DELAY = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_EXPECTED = 8'h1C;
  localparam logic [7:0] REG_REMAINING = 8'h20;
  localparam logic [7:0] REG_RATIO = 8'h24;

  // Control fields and reset values
  localparam int CB_INVERSE = 0;
  localparam int CB_UNDER = 1;
  localparam int CB_DLY_REL = 2;
  localparam int CB_RST_AFTER = 3;
  localparam int CB_CONT = 4;
  localparam int CB_MODE = 5;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h0C;
  localparam logic [15:0] PICKUP_RESET = 16'h2904;
  localparam logic [15:0] TIME_DIAL_RESET = 16'h0005;
  localparam logic [15:0] EXPONENT_RESET = 16'h0064;

  // Status fields
  localparam int SB_START = 0;
  localparam int SB_TRIP = 1;
  localparam int SB_BLOCKED = 2;
  localparam int SB_MODE = 4;

  // Hysteresis and arithmetic
  localparam int PCT_FULL = 100;
  localparam int HYST_OVER_PCT = 97;
  localparam int HYST_UNDER_PCT = 103;
  localparam int QF = 16;
  localparam int LOG_FRAC = 8;
  localparam int EXP_INT_MAX = 14;
  localparam int DIV_STEPS = 48;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_ON = 3'h0,
    MODE_BLOCKED = 3'h1,
    MODE_TEST = 3'h2,
    MODE_TEST_BLOCKED = 3'h3,
    MODE_OFF = 3'h4
  } psot_mode_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_RATIO = 3'h1,
    C_LOG = 3'h3,
    C_SCALE = 3'h2,
    C_EXP = 3'h6,
    C_TIME = 3'h7
  } psot_calc_t;
endpackage

/* File: core/psot_stage.sv */
/*
  One sequence voltage protection stage: pick-up comparator with hysteresis,
  start/trip/blocked logic with definite, instant and inverse timing, release
  handling, live readouts and an AXI4-Lite register slave.
  Assumes measured_level and block_in come from logic on aclk.
*/
// Chosen here: the register addresses and the AXI4-Lite register port.
// Notes on behaviour
// - Blocking input is sampled at each evaluation tick before pick-up is processed.
// - Pick-up without blocking asserts start and runs operate timing.
// - Pick-up with blocking asserts blocked only; no start, no trip timing.
// - Blocking during start drops start, then release timing runs as on drop-off.
// - Instant operation trips in the same evaluation as start.
// - Definite time trips after a fixed delay of continuous pick-up.
// - Inverse time is k/(r^a-1) over, k/(1-r^a) under.
// - Delay type chooses definite or inverse timing; definite by default.
// - Definite delay in 5 ms steps, default 40 ms, zero means instant.
// - Time dial k in 10 ms steps, default 50 ms, inverse only.
// - Exponent a in hundredths, default 1.00, inverse only.
// - Release delay in 5 ms steps, default 60 ms, holds start when enabled.
// - Delayed release drops start after release delay, else at once.
// - Timer reset after release clears timer only after full release delay.
// - Continue timing keeps the operate timer counting during release when timer reset after release is also set.
// - No trip during release unless pick-up returns first.
// - Expected operating time readout in ticks, recomputed each tick in inverse mode.
// - Remaining time to trip is shown while counting.
// - Ratio measured over pick-up level is shown live in hundredths.
// - Effective mode reported as on, blocked, test, test-blocked or off.
// - Release hysteresis is 97 % over and 103 % under of the level.
// - Direction setting selects over or under pick-up; over by default.
module psot_stage
  import psot_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Measurement and blocking
  input wire logic [15:0] measured_level,
  input wire logic block_in,
  // Stage outputs
  output logic stage_start,
  output logic stage_trip,
  output logic stage_blocked,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
    return (v == MAX_TICKS) ? v : v + TW'(1);
  endfunction

  function automatic logic [4:0] msb_pos(input logic [31:0] v);
    logic [4:0] p;
    p = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        p = 5'(i);
      end
    end
    return p;
  endfunction

  function automatic logic [31:0] exp_root(input logic [2:0] idx);
    logic [31:0] r;
    unique case (idx)
      3'h0: r = 32'h0001_6A0A;
      3'h1: r = 32'h0001_3070;
      3'h2: r = 32'h0001_172C;
      3'h3: r = 32'h0001_0B56;
      3'h4: r = 32'h0001_059B;
      3'h5: r = 32'h0001_02CA;
      3'h6: r = 32'h0001_0164;
      3'h7: r = 32'h0001_00B2;
    endcase
    return r;
  endfunction

  // Configuration registers
  logic [CTRL_W-1:0] ctrl;
  logic [15:0] pickup_level;
  logic [TW-1:0] op_delay;
  logic [15:0] time_dial;
  logic [15:0] exponent;
  logic [TW-1:0] rel_delay;
  // Stage state
  logic [31:0] tick_cnt;
  logic tick;
  logic eval_go;
  logic blk_q;
  logic pu_q;
  logic releasing;
  logic [TW-1:0] op_cnt;
  logic [TW-1:0] rel_cnt;
  logic [TW-1:0] inv_ticks;
  logic [TW:0] remaining;
  logic [31:0] ratio_pct;
  // Calculation engine
  psot_calc_t calc_st;
  logic dv_go;
  logic [47:0] dv_in_num;
  logic [31:0] dv_in_den;
  logic [47:0] dv_num;
  logic [31:0] dv_den;
  logic [31:0] dv_rem;
  logic [5:0] dv_cnt;
  logic [32:0] dv_trial;
  logic dv_done;
  logic [31:0] lg_m;
  logic [63:0] lg_sq;
  logic [5:0] lg_int;
  logic [LOG_FRAC-1:0] lg_frac;
  logic [3:0] st_cnt;
  logic [31:0] ex_acc;
  logic [63:0] ex_prod;
  logic [LOG_FRAC-1:0] ex_frac;
  logic [3:0] ex_shift;
  logic [31:0] p2;
  // Bus helpers
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] cur_word;
  logic [31:0] wr_val;
  logic wr_mapped;
  logic [31:0] rd_word;
  logic rd_mapped;
  // Derived
  psot_mode_t mode;
  logic stage_off;
  logic blk_now;
  logic inverse;
  logic under;
  logic [TW-1:0] op_target;
  logic instant;
  logic [TW-1:0] op_next;
  logic [TW-1:0] rel_next;
  logic [31:0] rel_over;
  logic [31:0] rel_under;

  always_comb begin
    mode = psot_mode_t'(ctrl[CB_MODE +: 3]);
    stage_off = (ctrl[CB_MODE +: 3] >= MODE_OFF);
    blk_now = blk_q || mode == MODE_BLOCKED || mode == MODE_TEST_BLOCKED;
  end

  assign inverse = ctrl[CB_INVERSE];
  assign under = ctrl[CB_UNDER];
  assign op_target = inverse ? inv_ticks : op_delay;
  assign instant = !inverse && op_delay == '0;
  assign op_next = sat_inc(op_cnt);
  assign rel_next = sat_inc(rel_cnt);
  assign rel_over = 32'((pickup_level * HYST_OVER_PCT) / PCT_FULL);
  assign rel_under = 32'((pickup_level * HYST_UNDER_PCT) / PCT_FULL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
      eval_go <= 1'b0;
    end else begin
      tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 32'h0000_0001;
      eval_go <= tick;
    end
  end

  // block sampled at tick, evaluated one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_q <= 1'b0;
      pu_q <= 1'b0;
    end else if (tick) begin
      blk_q <= block_in;
      if (!under) begin
        pu_q <= pu_q ? (32'(measured_level) >= rel_over) : (measured_level > pickup_level);
      end else begin
        pu_q <= pu_q ? (32'(measured_level) <= rel_under) : (measured_level < pickup_level);
      end
    end
  end

  // Start, trip, blocked and operate/release timers
  always_ff @(posedge aclk) begin
    if (!aresetn || stage_off) begin
      stage_start <= 1'b0;
      stage_trip <= 1'b0;
      stage_blocked <= 1'b0;
      releasing <= 1'b0;
      op_cnt <= '0;
      rel_cnt <= '0;
    end else if (eval_go) begin
      stage_blocked <= pu_q && blk_now;
      if (pu_q && !blk_now) begin
        stage_start <= 1'b1;
        releasing <= 1'b0;
        rel_cnt <= '0;
        op_cnt <= op_next;
        if (instant || op_next >= op_target) begin
          stage_trip <= 1'b1;
        end
      end else if (stage_trip || (!stage_start && !releasing)) begin
        stage_start <= 1'b0;
        stage_trip <= 1'b0;
        releasing <= 1'b0;
        op_cnt <= '0;
        rel_cnt <= '0;
      end else begin
        releasing <= 1'b1;
        // block drops start; delayed release holds start
        stage_start <= ctrl[CB_DLY_REL] && !blk_now && rel_next < rel_delay;
        if (!ctrl[CB_RST_AFTER]) begin
          op_cnt <= '0;
        end else if (ctrl[CB_CONT]) begin
          op_cnt <= op_next;
        end
        if (rel_next >= rel_delay) begin
          releasing <= 1'b0;
          rel_cnt <= '0;
          op_cnt <= '0;
        end else begin
          rel_cnt <= rel_next;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remaining <= '0;
    end else begin
      remaining <= stage_start ? {1'b0, op_target} - {1'b0, op_cnt} : '0;
    end
  end

  // Shared restoring divider
  assign dv_trial = {dv_rem, dv_num[47]};
  assign dv_done = !dv_go && dv_cnt == '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dv_num <= '0;
      dv_den <= '0;
      dv_rem <= '0;
      dv_cnt <= '0;
    end else if (dv_go) begin
      dv_num <= dv_in_num;
      dv_den <= dv_in_den;
      dv_rem <= '0;
      dv_cnt <= 6'(DIV_STEPS);
    end else if (dv_cnt != '0) begin
      dv_cnt <= dv_cnt - 6'h01;
      if (dv_trial >= {1'b0, dv_den}) begin
        dv_rem <= 32'(dv_trial - {1'b0, dv_den});
        dv_num <= {dv_num[46:0], 1'b1};
      end else begin
        dv_rem <= dv_trial[31:0];
        dv_num <= {dv_num[46:0], 1'b0};
      end
    end
  end

  assign lg_sq = lg_m * lg_m;
  assign ex_prod = ex_acc * exp_root(3'(LOG_FRAC - 32'(st_cnt)));
  assign p2 = ex_acc << ex_shift;

  // ratio, log2, scale by a, exp2, time division
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      calc_st <= C_IDLE;
      dv_go <= 1'b0;
      dv_in_num <= '0;
      dv_in_den <= '0;
      lg_m <= '0;
      lg_int <= '0;
      lg_frac <= '0;
      st_cnt <= '0;
      ex_acc <= '0;
      ex_frac <= '0;
      ex_shift <= '0;
      ratio_pct <= '0;
      inv_ticks <= '0;
    end else begin
      dv_go <= 1'b0;
      unique case (calc_st)
        C_IDLE: begin
          if (tick) begin
            dv_in_num <= {16'h0000, measured_level, 16'h0000};
            dv_in_den <= {16'h0000, pickup_level};
            dv_go <= 1'b1;
            calc_st <= C_RATIO;
          end
        end
        C_RATIO: begin
          if (dv_done) begin
            ratio_pct <= 32'((64'(dv_num[31:0]) * PCT_FULL) >> QF);
            lg_int <= 6'(msb_pos(dv_num[31:0] | 32'h0000_0001)) - 6'(QF);
            lg_m <= 32'((64'(dv_num[31:0] | 32'h0000_0001) << 30)
                        >> msb_pos(dv_num[31:0] | 32'h0000_0001));
            lg_frac <= '0;
            st_cnt <= 4'(LOG_FRAC);
            calc_st <= C_LOG;
          end
        end
        C_LOG: begin
          if (st_cnt != '0) begin
            st_cnt <= st_cnt - 4'h1;
            lg_frac <= {lg_frac[LOG_FRAC-2:0], lg_sq[61]};
            lg_m <= lg_sq[61] ? {1'b0, lg_sq[61:31]} : lg_sq[61:30];
          end else begin
            dv_in_num <= 48'((lg_int[5] ? 14'(-{lg_int, lg_frac}) : {lg_int, lg_frac})
                             * exponent);
            dv_in_den <= 32'(PCT_FULL);
            dv_go <= 1'b1;
            calc_st <= C_SCALE;
          end
        end
        C_SCALE: begin
          if (dv_done) begin
            ex_acc <= 32'h0001_0000;
            ex_frac <= dv_num[LOG_FRAC-1:0];
            ex_shift <= (dv_num[47:LOG_FRAC] > 40'(EXP_INT_MAX)) ? 4'(EXP_INT_MAX)
                                                                 : dv_num[LOG_FRAC+3:LOG_FRAC];
            st_cnt <= 4'(LOG_FRAC);
            calc_st <= C_EXP;
          end
        end
        C_EXP: begin
          if (st_cnt != '0) begin
            st_cnt <= st_cnt - 4'h1;
            ex_frac <= {ex_frac[LOG_FRAC-2:0], 1'b0};
            if (ex_frac[LOG_FRAC-1]) begin
              ex_acc <= ex_prod[47:16];
            end
          end else begin
            // k in 10 ms units gives 2k ticks per second of formula
            dv_in_num <= under ? 48'((64'(time_dial) * p2) << 1)
                               : {15'h0000, time_dial, 17'h0_0000};
            dv_in_den <= p2 - 32'h0001_0000;
            dv_go <= 1'b1;
            calc_st <= C_TIME;
          end
        end
        C_TIME: begin
          if (dv_done) begin
            inv_ticks <= (dv_num > 48'(MAX_TICKS)) ? MAX_TICKS : dv_num[TW-1:0];
            calc_st <= C_IDLE;
          end
        end
        default: calc_st <= C_IDLE;
      endcase
    end
  end

  // Current value of a writable register
  always_comb begin
    cur_word = '0;
    wr_mapped = 1'b1;
    unique case (aw_addr_q)
      REG_CTRL: cur_word = 32'(ctrl);
      REG_PICKUP: cur_word = 32'(pickup_level);
      REG_OP_DELAY: cur_word = 32'(op_delay);
      REG_TIME_DIAL: cur_word = 32'(time_dial);
      REG_EXPONENT: cur_word = 32'(exponent);
      REG_REL_DELAY: cur_word = 32'(rel_delay);
      REG_STATUS, REG_EXPECTED, REG_REMAINING, REG_RATIO: cur_word = '0;
      default: wr_mapped = 1'b0;
    endcase
    wr_val = merge_strb(cur_word, w_data_q, w_strb_q);
  end

  // Read decode
  always_comb begin
    rd_word = '0;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      REG_CTRL: rd_word = 32'(ctrl);
      REG_PICKUP: rd_word = 32'(pickup_level);
      REG_OP_DELAY: rd_word = 32'(op_delay);
      REG_TIME_DIAL: rd_word = 32'(time_dial);
      REG_EXPONENT: rd_word = 32'(exponent);
      REG_REL_DELAY: rd_word = 32'(rel_delay);
      REG_STATUS: begin
        rd_word[SB_START] = stage_start;
        rd_word[SB_TRIP] = stage_trip;
        rd_word[SB_BLOCKED] = stage_blocked;
        rd_word[SB_MODE +: 3] = stage_off ? MODE_OFF : mode;
      end
      REG_EXPECTED: rd_word = 32'(instant ? '0 : op_target);
      REG_REMAINING: rd_word = 32'(signed'(remaining));
      REG_RATIO: rd_word = ratio_pct;
      default: rd_mapped = 1'b0;
    endcase
  end

  // Write channel and register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      ctrl <= CTRL_RESET;
      pickup_level <= PICKUP_RESET;
      op_delay <= OP_DELAY_RESET;
      time_dial <= TIME_DIAL_RESET;
      exponent <= EXPONENT_RESET;
      rel_delay <= REL_DELAY_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
        s_axi_awready <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        unique case (aw_addr_q)
          REG_CTRL: ctrl <= wr_val[CTRL_W-1:0];
          REG_PICKUP: pickup_level <= wr_val[15:0];
          // delays held in 5 ms ticks
          REG_OP_DELAY: op_delay <= (wr_val > 32'(MAX_TICKS)) ? MAX_TICKS : wr_val[TW-1:0];
          REG_TIME_DIAL: time_dial <= wr_val[15:0];
          REG_EXPONENT: exponent <= wr_val[15:0];
          REG_REL_DELAY: rel_delay <= (wr_val > 32'(MAX_TICKS)) ? MAX_TICKS : wr_val[TW-1:0];
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* File: sim/psot_properties.sv */
/* Port checker for psot_stage.
   Assumes outputs change only at evaluation ticks. */
module psot_chk
  import psot_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Stage
  input wire logic stage_start,
  input wire logic stage_trip,
  input wire logic stage_blocked,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int unsigned gap;
  always_ff @(posedge aclk) begin
    if (!aresetn) gap <= TICK_CYCLES;
    else if ($changed(stage_start)) gap <= 1;
    else if (gap < TICK_CYCLES) gap <= gap + 1;
  end
  AST_TRIP_START: assert property (stage_trip |-> stage_start)
    else $error("trip without start");
  AST_TRIP_CLR: assert property ($fell(stage_trip) |-> $fell(stage_start))
    else $error("trip cleared apart");
  AST_BLK: assert property (stage_blocked |-> !stage_start && !stage_trip)
    else $error("blocked with start");
  AST_TICK: assert property ($changed(stage_start) |-> gap >= TICK_CYCLES)
    else $error("start off tick");
  AST_WLAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_ARBUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  AST_RST: assert property (disable iff (1'b0)
    !aresetn |=> !stage_start && !stage_trip && !stage_blocked)
    else $error("output after reset");
  cover property ($rose(stage_trip) && $rose(stage_start));
  cover property ($rose(stage_blocked));
  cover property ($fell(stage_start) && !stage_trip);
endmodule

bind psot_stage psot_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.aclk, .aresetn, .stage_start,
  .stage_trip, .stage_blocked, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

/* File: sim/psot_src.sv */
/* Source model for the stage: measured level and blocking line.
   Assumes the bench gives commands on aclk. */
module psot_src (
  // Clock
  input wire logic aclk,
  // Commands
  input wire logic [15:0] lvl_cmd,
  input wire logic blk_cmd,
  // To stage
  output logic [15:0] measured_level,
  output logic block_in
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge aclk) begin
    measured_level <= lvl_cmd;
    block_in <= blk_cmd;
  end
endmodule

/* File: sim/tb_psot_stage.sv */
/* Bench for psot_stage: register and timing scenarios.
   Assumes a 200-cycle tick and the psot_src model. */
module tb_psot_stage
  import psot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 200;
  localparam logic [15:0] HI = 16'h5208;
  logic aclk = 1'b0, aresetn = 1'b0, blk = 1'b0;
  logic [15:0] lvl = 16'h0000;
  logic [15:0] ml;
  logic bi, st, tr, bk, awr, wrd, bv, arr, rv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [1:0] brs, rrs;
  logic [31:0] rdt, q;
  int err_total = 0, n_compared = 0, cyc = 0, n, ntr = 0;
  longint t0;
  logic [31:0] rv0[6] = '{32'h0000_000C, 32'h0000_2904, 32'h0000_0008, 32'h0000_0005,
    32'h0000_0064, 32'h0000_000C};
  logic [7:0] tc[3] = '{8'h1C, 8'h0C, 8'h04};
  int te[3] = '{6, 7, 11};
  logic [15:0] hl[2][3] = '{'{16'h2905, 16'h2832, 16'h2760}, '{16'h2710, 16'h29D6, 16'h2AA8}};
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    if (tr) ntr <= ntr + 1;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      stop_test();
    end
  end
  psot_src src (.aclk, .lvl_cmd(lvl), .blk_cmd(blk), .measured_level(ml), .block_in(bi));
  psot_stage #(.TICK_CYCLES(TK)) dut (.aclk, .aresetn, .measured_level(ml), .block_in(bi),
    .stage_start(st), .stage_trip(tr), .stage_blocked(bk), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(brs), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rre));
  task automatic stop_test();
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] v);
    n_compared++;
    if (v !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic tk(int k);
    repeat (k * TK) @(posedge aclk);
  endtask
  task automatic wf(ref logic s, input logic v);
    repeat (40 * TK) begin
      if (s === v) break;
      @(posedge aclk);
    end
    if (s !== v) begin
      err_total++;
      $display("[ERR] wait expected %b seen %b", v, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    @(posedge aclk);
    while (awv || wv || !bv) begin
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      @(posedge aclk);
    end
    bre <= 1'b0;
    chk("bresp", 32'(r), 32'(brs));
  endtask
  task automatic rd(logic [7:0] a, logic [1:0] r = RESP_OKAY);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    @(posedge aclk);
    while (arv || !rv) begin
      if (arr) arv <= 1'b0;
      @(posedge aclk);
    end
    rre <= 1'b0;
    q = rdt;
    chk("rresp", 32'(r), 32'(rrs));
  endtask
  task automatic rc(logic [7:0] a, logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic idl();
    lvl <= 16'h0000;
    blk <= 1'b0;
    wf(st, 1'b0);
    tk(8);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rc(8'(4 * i), rv0[i]);
    rd(8'h40, RESP_SLVERR);
    chk("unmapped", 32'h0000_0000, q);
    wr(8'h40, 32'h0000_0001, RESP_SLVERR);
    wr(REG_STATUS, 32'hFFFF_FFFF);
    rc(REG_STATUS, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      wr(REG_CTRL, 32'(i * 32 + 12));
      tk(1);
      rc(REG_STATUS, 32'(i * 16));
    end
    wr(REG_CTRL, 32'h0000_000C);
    wr(REG_REL_DELAY, 32'h0000_0004);
    lvl <= HI;
    wf(st, 1'b1);
    t0 = $time;
    rc(REG_REMAINING, 32'h0000_0007);
    wf(tr, 1'b1);
    chk("definite", 32'(7 * TK * 40), 32'($time - t0));
    rc(REG_STATUS, 32'h0000_0003);
    rc(REG_RATIO, 32'h0000_00C8);
    rc(REG_EXPECTED, 32'h0000_0008);
    lvl <= 16'h0000;
    wf(st, 1'b0);
    chk("trip clear", 0, 32'(tr));
    tk(8);
    wr(REG_OP_DELAY, 32'h0000_0000);
    lvl <= HI;
    wf(st, 1'b1);
    chk("instant", 1, 32'(tr));
    rc(REG_EXPECTED, 32'h0000_0000);
    idl();
    wr(REG_OP_DELAY, 32'h0000_0064);
    for (int i = 0; i < 2; i++) begin
      wr(REG_CTRL, i ? 32'h0000_000C : 32'h0000_0008);
      lvl <= HI;
      wf(st, 1'b1);
      t0 = $time;
      tk(3);
      lvl <= 16'h0000;
      wf(st, 1'b0);
      n = int'(($time - t0) / 40);
      chk("release", 32'(i ? 7 * TK : 4 * TK), 32'(n));
      tk(8);
    end
    wr(REG_OP_DELAY, 32'h0000_0006);
    for (int i = 0; i < 3; i++) begin
      wr(REG_CTRL, 32'(tc[i]));
      lvl <= HI;
      wf(st, 1'b1);
      t0 = $time;
      n = ntr;
      tk(3);
      lvl <= 16'h0000;
      tk(2);
      chk("no trip", 32'(n), 32'(ntr));
      lvl <= HI;
      wf(tr, 1'b1);
      chk("timer", 32'(te[i] * TK * 40), 32'($time - t0));
      idl();
    end
    wr(REG_CTRL, 32'h0000_000C);
    blk <= 1'b1;
    tk(1);
    lvl <= HI;
    tk(3);
    chk("blocked", 1, 32'(bk));
    rc(REG_STATUS, 32'h0000_0004);
    idl();
    lvl <= HI;
    wf(st, 1'b1);
    t0 = $time;
    tk(2);
    blk <= 1'b1;
    wf(st, 1'b0);
    chk("block drop", 32'(3 * TK * 40), 32'($time - t0));
    idl();
    wr(REG_OP_DELAY, 32'h0000_0064);
    for (int i = 0; i < 2; i++) begin
      lvl <= hl[i][0];
      wr(REG_CTRL, i ? 32'h0000_000A : 32'h0000_0008);
      wf(st, 1'b1);
      lvl <= hl[i][1];
      tk(3);
      chk("hyst hold", 1, 32'(st));
      lvl <= hl[i][2];
      tk(2);
      chk("hyst drop", 0, 32'(st));
    end
    wr(REG_CTRL, 32'h0000_000D);
    lvl <= HI;
    wf(st, 1'b1);
    tk(2);
    rc(REG_EXPECTED, 32'h0000_000A);
    stop_test();
  end
endmodule
